//--- rtl/sscp_port.sv
// Synchronous serial channel with tail mark, behind an AXI4-Lite slave.
// Assumes one clock clk_sys; sck_i and si_i are asynchronous pins.
`timescale 1ns/1ps
`include "sscp_regs.svh"
module sscp_port (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [17:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [17:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic si_i,
    output logic so_o,
    output logic irq
);
    // =====================================================================
    // AXI4-Lite write side: address and data latched in either order
    logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
    logic [15:0] aw_idx_q;
    logic [7:0] w_byte_q;
    logic w_en_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    assign awready = !aw_full_q && !bvalid_q;
    assign wready = !w_full_q && !bvalid_q;
    wire wr_fire = aw_full_q && w_full_q && !bvalid_q;
    wire wr_ok = wr_fire && w_en_q;
    wire wr_ctrl = wr_ok && (aw_idx_q == `SSCP_IDX_CTRL);
    wire wr_csr = wr_ok && (aw_idx_q == `SSCP_IDX_CSR);
    wire wr_up = wr_ok && (aw_idx_q == `SSCP_IDX_DATA_UP);
    wire wr_lo = wr_ok && (aw_idx_q == `SSCP_IDX_DATA_LO);
    wire wr_iclr = wr_ok && (aw_idx_q == `SSCP_IDX_IRQ_CLR);
    wire wr_ien = wr_ok && (aw_idx_q == `SSCP_IDX_IRQ_EN);
    wire wr_hit = (aw_idx_q >= `SSCP_IDX_CTRL) && (aw_idx_q <= `SSCP_IDX_IRQ_EN);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            aw_idx_q <= 16'h0000;
            w_byte_q <= 8'h00;
            w_en_q <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_full_q <= 1'b1;
                aw_idx_q <= awaddr[17:2];
            end
            if (wvalid && wready) begin
                w_full_q <= 1'b1;
                w_byte_q <= wdata[7:0];
                w_en_q <= wstrb[0];
            end
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? 2'h0 : 2'h2;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    // =====================================================================
    // Control register and channel state
    logic [7:0] ctrl_q;
    sscp_pkg::sscp_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic sck_q, so_q, tail_ph_q, overrun_flag_q, overrun_flag_seen_q;
    logic [15:0] data_q;
    logic [1:0] ist_q, ien_q;

    wire sscp_pkg::sscp_mode_t mode = sscp_pkg::sscp_mode_t'(ctrl_q[7:6]);
    wire tail_en = ctrl_q[`SSCP_CTRL_TAIL_EN];
    wire tail_latch = ctrl_q[`SSCP_CTRL_TAIL_TYPE];
    wire int_clk = !ctrl_q[`SSCP_CTRL_CLK_SRC];
    wire busy = (state_q != sscp_pkg::st_idle);
    wire in_shift = (state_q == sscp_pkg::st_shift);
    wire in_tail = (state_q == sscp_pkg::st_tail);
    // Reserved mode 11 is run as 8-bit so the channel never hangs
    wire [3:0] last_bit = (mode == sscp_pkg::mode_16bit) ? 4'd15 : 4'd7;
    wire start = wr_csr && w_byte_q[`SSCP_CSR_STF] && !busy
                 && (mode != sscp_pkg::mode_cont);
    wire abort = wr_ctrl && busy;

    // =====================================================================
    // Serial clock sources
    logic tick, ext_rise, ext_fall, si_lvl;

    sscp_prescaler u_pre (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .sel(ctrl_q[2:0]),
        .restart(start),
        .tick(tick)
    );

    sscp_sync3 #(.RST_VAL(1'b1)) u_sck_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .din(sck_i),
        .dout(),
        .rise(ext_rise),
        .fall(ext_fall)
    );

    sscp_sync3 #(.RST_VAL(1'b0)) u_si_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .din(si_i),
        .dout(si_lvl),
        .rise(),
        .fall()
    );

    wire fall_ev = int_clk ? (tick && sck_q) : ext_fall;
    wire rise_ev = int_clk ? (tick && !sck_q) : ext_rise;
    wire last_rise = in_shift && rise_ev && (bit_cnt_q == last_bit);
    wire fin = !abort && ((last_rise && !tail_en) || (in_tail && tick && tail_ph_q));
    // An external clock with nothing pending means the partner overran us
    wire ov_set = !int_clk && !busy && ext_fall;
    wire cont_run = (mode == sscp_pkg::mode_cont) && int_clk && !busy;

    // =====================================================================
    // Transfer sequencer
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `SSCP_CTRL_RST;
            state_q <= sscp_pkg::st_idle;
            bit_cnt_q <= 4'h0;
            sck_q <= 1'b1;
            so_q <= 1'(`SSCP_CSR_RST >> `SSCP_CSR_SOL);
            tail_ph_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= w_byte_q;
            end
            if (abort) begin
                state_q <= sscp_pkg::st_idle;
                sck_q <= 1'b1;
            end else if (start) begin
                state_q <= sscp_pkg::st_shift;
                bit_cnt_q <= 4'h0;
                sck_q <= 1'b1;
            end else begin
                case (state_q)
                    sscp_pkg::st_idle: begin
                        sck_q <= cont_run ? (sck_q ^ tick) : 1'b1;
                        if (wr_csr) begin
                            so_q <= w_byte_q[`SSCP_CSR_SOL];
                        end
                    end
                    sscp_pkg::st_shift: begin
                        if (int_clk && tick) begin
                            sck_q <= !sck_q;
                        end
                        if (fall_ev) begin
                            so_q <= data_q[0];
                        end
                        if (rise_ev) begin
                            bit_cnt_q <= bit_cnt_q + 4'd1;
                        end
                        if (last_rise && tail_en) begin
                            state_q <= sscp_pkg::st_tail;
                            tail_ph_q <= 1'b0;
                            so_q <= 1'b0;
                        end else if (last_rise) begin
                            state_q <= sscp_pkg::st_idle;
                        end
                    end
                    sscp_pkg::st_tail: begin
                        // Clock idles high; data low for a half period, then
                        // low again (hold) or high (latch) for a half period
                        sck_q <= 1'b1;
                        if (tick && !tail_ph_q) begin
                            tail_ph_q <= 1'b1;
                            so_q <= tail_latch;
                        end else if (tick) begin
                            state_q <= sscp_pkg::st_idle;
                        end
                    end
                    default: state_q <= sscp_pkg::st_idle;
                endcase
            end
        end
    end

    // Data holds no reset; contents are undefined until software writes
    // Limitation: received bits lag the pin by about four cycles, so an internal
    // clock reads them reliably only at divide-by-16 and slower
    always_ff @(posedge clk_sys) begin
        if (wr_up) begin
            data_q[15:8] <= w_byte_q;
        end else if (in_shift && rise_ev && mode == sscp_pkg::mode_16bit) begin
            data_q[15:8] <= {si_lvl, data_q[15:9]};
        end
        if (wr_lo) begin
            data_q[7:0] <= w_byte_q;
        end else if (in_shift && rise_ev) begin
            data_q[7:0] <= {(mode == sscp_pkg::mode_16bit) ? data_q[8] : si_lvl,
                            data_q[7:1]};
        end
    end

    // =====================================================================
    // Overrun flag and interrupt registers; a set beats a same-cycle clear
    wire csr_rd = arvalid && arready && (araddr[17:2] == `SSCP_IDX_CSR);
    wire overrun_flag_clr = wr_csr && !w_byte_q[`SSCP_CSR_OVERRUN_FLAG] && overrun_flag_seen_q;
    wire [1:0] ev = {ov_set, fin};
    wire [1:0] iclr = wr_iclr ? w_byte_q[1:0] : 2'b00;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            overrun_flag_q <= 1'b0;
            overrun_flag_seen_q <= 1'b0;
            ist_q <= 2'b00;
            ien_q <= 2'b00;
        end else begin
            overrun_flag_q <= ov_set || (overrun_flag_q && !overrun_flag_clr);
            if (csr_rd) begin
                overrun_flag_seen_q <= overrun_flag_q;
            end else if (overrun_flag_clr) begin
                overrun_flag_seen_q <= 1'b0;
            end
            ist_q <= ev | (ist_q & ~iclr);
            if (wr_ien) begin
                ien_q <= w_byte_q[1:0];
            end
        end
    end
    assign irq = |(ist_q & ien_q);

    // =====================================================================
    // Read side
    wire [15:0] ar_idx = araddr[17:2];
    wire [7:0] csr_val = {1'b1, so_q, overrun_flag_q, 3'b111, in_tail, busy};
    wire rd_ctrl = (ar_idx == `SSCP_IDX_CTRL);
    wire rd_csr = (ar_idx == `SSCP_IDX_CSR);
    wire rd_up = (ar_idx == `SSCP_IDX_DATA_UP);
    wire rd_lo = (ar_idx == `SSCP_IDX_DATA_LO);
    wire rd_ist = (ar_idx == `SSCP_IDX_IRQ_STAT);
    wire rd_ien = (ar_idx == `SSCP_IDX_IRQ_EN);
    wire rd_hit = (ar_idx >= `SSCP_IDX_CTRL) && (ar_idx <= `SSCP_IDX_IRQ_EN);
    wire [7:0] rd_byte = rd_ctrl ? ctrl_q :
                         rd_csr ? csr_val :
                         rd_up ? data_q[15:8] :
                         rd_lo ? data_q[7:0] :
                         rd_ist ? {6'h00, ist_q} :
                         rd_ien ? {6'h00, ien_q} : 8'h00;

    assign arready = !rvalid_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h0;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= {24'h000000, rd_byte};
            rresp_q <= rd_hit ? 2'h0 : 2'h2;
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // =====================================================================
    // Pins
    assign sck_oe = int_clk;
    assign sck_o = sck_q;
    assign so_o = so_q;

    // =====================================================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    logic [4:0] rises_q;
    logic [9:0] gap_q;
    logic [2:0] sel_q;
    logic sel_mv_q;
    // Half period as a power of two, taken from the divide ratio of each code
    wire [3:0] half_log = (ctrl_q[2:0] == 3'h0) ? 4'd9 :
                          (ctrl_q[2:0] == 3'h1) ? 4'd7 : 4'd7 - {1'b0, ctrl_q[2:0]};
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rises_q <= 5'h00;
            gap_q <= 10'h000;
            sel_q <= 3'h0;
            sel_mv_q <= 1'b0;
        end else begin
            rises_q <= start ? 5'h00 : rises_q + {4'h0, in_shift && rise_ev};
            gap_q <= (tick || start) ? 10'h000 : gap_q + 10'd1;
            sel_q <= ctrl_q[2:0];
            sel_mv_q <= !(tick || start) && (sel_mv_q || (ctrl_q[2:0] != sel_q));
        end
    end

    chk_word_len: assert property (last_rise |-> rises_q == {1'b0, last_bit})
        else $error("word length differs from mode");
    chk_tail_flag: assert property (last_rise && tail_en && !abort |=> in_tail && !fin)
        else $error("tail mark not entered");
    chk_tail_level: assert property (in_tail && tail_ph_q |-> so_o == tail_latch)
        else $error("tail level wrong");
    chk_sck_dir: assert property (sck_oe != ctrl_q[`SSCP_CTRL_CLK_SRC])
        else $error("clock pin direction wrong");
    chk_div_gap: assert property (tick && !sel_mv_q && ctrl_q[2:0] == sel_q
                                  |-> gap_q == (10'd1 << half_log) - 10'd1)
        else $error("prescaler tick spacing wrong");
    chk_abort_idle: assert property (abort |=> !busy)
        else $error("control write did not abort");
    chk_done_irq: assert property (fin |=> ist_q[`SSCP_IRQ_DONE] && !busy)
        else $error("completion not flagged");
    chk_lsb_out: assert property (in_shift && fall_ev && !abort |=> so_o == $past(data_q[0]))
        else $error("wrong bit driven");
    chk_overrun: assert property (ov_set |=> overrun_flag_q [*2])
        else $error("overrun not held");
    chk_busy_start: assert property (start |=> busy ##0 csr_val[`SSCP_CSR_STF])
        else $error("start flag not set");

    cov_byte_done: cover property (fin && mode == sscp_pkg::mode_8bit && !tail_en);
    cov_word_done: cover property (fin && mode == sscp_pkg::mode_16bit);
    cov_latch_tail: cover property (fin && in_tail && tail_latch);
    cov_overrun: cover property (ov_set);
endmodule

//--- rtl/sscp_regs.svh
// Register indices, field positions, reset values and divider counts of the
// tail-mark serial port. Assumes the includer reaches registers at 4 * index.
`ifndef SSCP_REGS_SVH
`define SSCP_REGS_SVH

// =====================================================================
// Register indices (byte address is four times the index)
`define SSCP_IDX_CTRL 16'hffa0
`define SSCP_IDX_CSR 16'hffa1
`define SSCP_IDX_DATA_UP 16'hffa2
`define SSCP_IDX_DATA_LO 16'hffa3
`define SSCP_IDX_IRQ_STAT 16'hffa4
`define SSCP_IDX_IRQ_CLR 16'hffa5
`define SSCP_IDX_IRQ_EN 16'hffa6

// =====================================================================
// Reset values
`define SSCP_CTRL_RST 8'h00
`define SSCP_CSR_RST 8'h9c

// =====================================================================
// Field positions
`define SSCP_CTRL_TAIL_EN 5
`define SSCP_CTRL_TAIL_TYPE 4
`define SSCP_CTRL_CLK_SRC 3
`define SSCP_CSR_SOL 6
`define SSCP_CSR_OVERRUN_FLAG 5
`define SSCP_CSR_TAIL_SENDING_FLAG 1
`define SSCP_CSR_STF 0
`define SSCP_IRQ_DONE 0
`define SSCP_IRQ_OVR 1

// =====================================================================
// Half serial-clock periods in system cycles, per prescale code
`define SSCP_HALF_0 10'd512
`define SSCP_HALF_1 10'd128
`define SSCP_HALF_2 10'd32
`define SSCP_HALF_3 10'd16
`define SSCP_HALF_4 10'd8
`define SSCP_HALF_5 10'd4
`define SSCP_HALF_6 10'd2
`define SSCP_HALF_7 10'd1

`endif

//--- rtl/sscp_pkg.sv
// Types shared by the tail-mark serial port.
// Assumes nothing beyond a SystemVerilog compiler.
package sscp_pkg;
    typedef enum logic [1:0] {st_idle, st_shift, st_tail} sscp_state_t;
    typedef enum logic [1:0] {mode_8bit, mode_16bit, mode_cont, mode_rsvd} sscp_mode_t;
endpackage

//--- rtl/sscp_sync3.sv
// Three-stage input synchroniser with agreement filter and edge pulses.
// Assumes din is asynchronous to clk_sys.
`timescale 1ns/1ps
module sscp_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic din,
    output logic dout,
    output logic rise,
    output logic fall
);
    logic s1_q, s2_q, s3_q, lvl_q;
    wire agree = (s2_q == s3_q);
    wire lvl_d = agree ? s3_q : lvl_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            lvl_q <= RST_VAL;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign dout = lvl_q;
    assign rise = lvl_d & ~lvl_q;
    assign fall = ~lvl_d & lvl_q;
endmodule

//--- rtl/sscp_prescaler.sv
// Prescaler: one-cycle tick every half serial-clock period.
// Assumes restart is a one-cycle pulse from the same clock.
`timescale 1ns/1ps
`include "sscp_regs.svh"
module sscp_prescaler (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [2:0] sel,
    input wire logic restart,
    output logic tick
);
    logic [9:0] cnt_q, cnt_d;
    logic [9:0] half;

    always_comb begin
        case (sel)
            3'h0: half = `SSCP_HALF_0;
            3'h1: half = `SSCP_HALF_1;
            3'h2: half = `SSCP_HALF_2;
            3'h3: half = `SSCP_HALF_3;
            3'h4: half = `SSCP_HALF_4;
            3'h5: half = `SSCP_HALF_5;
            3'h6: half = `SSCP_HALF_6;
            default: half = `SSCP_HALF_7;
        endcase
    end

    assign tick = !restart && (cnt_q >= half - 10'd1);
    assign cnt_d = (restart || tick) ? 10'h000 : cnt_q + 10'd1;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 10'h000;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

//--- dv/sscp_periph.sv
// Behavioural serial peripheral on the clock and data pins.
// Assumes the port drives sck_o/so_o and samples si_i; own clock idles high.
`timescale 1ns/1ps
module sscp_periph (
    input wire logic sck_o,
    input wire logic sck_oe,
    input wire logic so_o,
    input wire logic load,
    input wire logic [15:0] tx_word,
    input wire logic [4:0] nbits,
    input wire logic ext_go,
    input wire logic [4:0] ext_pulses,
    output logic sck_i,
    output logic si_i,
    output logic [15:0] rx_word
);
    logic ext_sck = 1'b1;
    int idx = 0;
    // =========================================================
    // Pin level: port drives when enabled, else our clock
    assign sck_i = sck_oe ? sck_o : ext_sck;
    initial si_i = 1'b0;
    always @(posedge load) idx = 0;
    // Drive on fall, LSB first; silent after the word and in clock-only mode
    always @(negedge sck_i) if (idx < nbits) begin
        si_i = tx_word[idx];
        idx++;
    end
    // Sample on rise; a released line flips so stale data never matches
    always @(posedge sck_i) begin
        rx_word = {so_o, rx_word[15:1]};
        if (idx >= nbits) #40 si_i = ~si_i;
    end
    always @(posedge ext_go) repeat (ext_pulses) begin
        #64 ext_sck = 1'b0;
        #64 ext_sck = 1'b1;
    end
endmodule

//--- dv/tb_sync_serial_tail_mark_port.sv
// Self-checking bench for the tail-mark serial port over AXI4-Lite.
// Assumes sscp_periph stands on the serial pins as the far side.
`timescale 1ns/1ps
`include "sscp_regs.svh"
module tb_sync_serial_tail_mark_port;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [17:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic awready, wready, bvalid, arready, rvalid, sck_i, sck_o, sck_oe, si_i, so_o, irq;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata;
    logic load = 1'b0, ext_go = 1'b0, p;
    logic [15:0] tx_word = '0;
    logic [15:0] rx_word;
    logic [4:0] nbits = '0, ext_pulses = '0;
    logic [7:0] rd;
    int fail_count = 0, checked = 0, n;
    localparam int half_tab [8] = '{512, 128, 32, 16, 8, 4, 2, 1};

    sscp_port dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe),
        .si_i(si_i), .so_o(so_o), .irq(irq));
    sscp_periph per_u (.sck_o(sck_o), .sck_oe(sck_oe), .so_o(so_o), .load(load),
        .tx_word(tx_word), .nbits(nbits), .ext_go(ext_go), .ext_pulses(ext_pulses),
        .sck_i(sck_i), .si_i(si_i), .rx_word(rx_word));

    // =========================================================
    // Bus and check tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t ns: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic a, w, b;
        a = 1'b0;
        w = 1'b0;
        b = 1'b0;
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(a && w)) begin
            @(negedge clk_sys);
            a = a | (awvalid & awready);
            w = w | (wvalid & wready);
            @(posedge clk_sys);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        while (!b) begin
            @(negedge clk_sys);
            b = bvalid;
            @(posedge clk_sys);
        end
        bready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd_reg(input logic [15:0] idx);
        logic r;
        r = 1'b0;
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r) begin
            @(negedge clk_sys);
            r = arready;
            @(posedge clk_sys);
        end
        arvalid <= 1'b0;
        r = 1'b0;
        while (!r) begin
            @(negedge clk_sys);
            r = rvalid;
            rd = rdata[7:0];
            rs = rresp;
            @(posedge clk_sys);
        end
        rready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wait_idle;
        do rd_reg(`SSCP_IDX_CSR); while (rd[0]);
    endtask
    task automatic setup_far(input logic [15:0] w, input logic [4:0] nb);
        tx_word <= w;
        nbits <= nb;
        load <= 1'b1;
        @(posedge clk_sys);
        load <= 1'b0;
    endtask
    task automatic pulses(input logic [4:0] k);
        ext_pulses <= k;
        ext_go <= 1'b1;
        @(posedge clk_sys);
        ext_go <= 1'b0;
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial forever #4 clk_sys = ~clk_sys;
    // Longest case is the divide-by-1024 half period plus a few short frames
    initial begin
        #400000;
        fail_count++;
        close_out();
    end

    // =========================================================
    // Test sequence; mode 11 is never programmed
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        chk(sck_oe, 1'b1);
        rd_reg(`SSCP_IDX_CTRL);
        chk(rd, 8'h00);
        rd_reg(`SSCP_IDX_CSR);
        chk(rd, 8'h9c);
        rd_reg(`SSCP_IDX_IRQ_EN);
        chk(rd, 8'h00);
        rd_reg(16'hffa7);
        chk(rs, 2'b10);
        wr(`SSCP_IDX_IRQ_EN, 8'h01);
        wr(`SSCP_IDX_CTRL, 8'h04);
        wr(`SSCP_IDX_DATA_LO, 8'ha5);
        setup_far(16'h003c, 5'd8);
        wr(`SSCP_IDX_CSR, 8'h01);
        rd_reg(`SSCP_IDX_CSR);
        chk(rd[0], 1'b1);
        wait_idle();
        chk(irq, 1'b1);
        chk(rx_word[15:8], 8'ha5);
        rd_reg(`SSCP_IDX_DATA_LO);
        chk(rd, 8'h3c);
        wr(`SSCP_IDX_IRQ_EN, 8'h00);
        chk(irq, 1'b0);
        rd_reg(`SSCP_IDX_IRQ_STAT);
        chk(rd, 8'h01);
        wr(`SSCP_IDX_IRQ_CLR, 8'h01);
        wr(`SSCP_IDX_IRQ_EN, 8'h01);
        chk(irq, 1'b0);
        wr(`SSCP_IDX_CTRL, 8'h44);
        wr(`SSCP_IDX_DATA_UP, 8'h12);
        wr(`SSCP_IDX_DATA_LO, 8'h34);
        setup_far(16'hbeef, 5'd16);
        wr(`SSCP_IDX_CSR, 8'h01);
        wait_idle();
        chk(rx_word, 16'h1234);
        rd_reg(`SSCP_IDX_DATA_UP);
        chk(rd, 8'hbe);
        rd_reg(`SSCP_IDX_DATA_LO);
        chk(rd, 8'hef);
        for (int t = 0; t < 2; t++) begin
            wr(`SSCP_IDX_CTRL, {3'b001, t[0], 4'h2});
            wr(`SSCP_IDX_CSR, 8'h01);
            rd_reg(`SSCP_IDX_CSR);
            chk(rd[1], 1'b0);
            n = 0;
            do begin
                rd_reg(`SSCP_IDX_CSR);
                n++;
            end while (!rd[1] && n < 200);
            chk(rd[1], 1'b1);
            wait_idle();
            chk(so_o, t[0]);
            chk(rd[6], t[0]);
            chk(rd[1], 1'b0);
        end
        wr(`SSCP_IDX_IRQ_CLR, 8'h03);
        for (int k = 0; k < 8; k++) begin
            wr(`SSCP_IDX_CTRL, {5'b00000, k[2:0]});
            wr(`SSCP_IDX_CSR, 8'h01);
            if (k == 0) rd_reg(`SSCP_IDX_CSR);
            if (k == 0) chk(rd[0], 1'b1);
            @(negedge clk_sys);
            while (sck_o !== 1'b1) @(negedge clk_sys);
            while (sck_o !== 1'b0) @(negedge clk_sys);
            n = 0;
            while (sck_o === 1'b0) begin
                n++;
                @(negedge clk_sys);
            end
            chk(n, half_tab[k]);
            @(posedge clk_sys);
            wr(`SSCP_IDX_CTRL, {5'b00000, k[2:0]});
            rd_reg(`SSCP_IDX_CSR);
            chk(rd[0], 1'b0);
            rd_reg(`SSCP_IDX_IRQ_STAT);
            chk(rd[0], 1'b0);
        end
        wr(`SSCP_IDX_CTRL, 8'h87);
        wr(`SSCP_IDX_CSR, 8'h01);
        rd_reg(`SSCP_IDX_CSR);
        chk(rd[0], 1'b0);
        n = 0;
        @(negedge clk_sys);
        p = sck_o;
        repeat (16) begin
            @(negedge clk_sys);
            if (sck_o !== p) n++;
            p = sck_o;
        end
        @(posedge clk_sys);
        chk(n, 16);
        wr(`SSCP_IDX_CTRL, 8'h08);
        chk(sck_oe, 1'b0);
        wr(`SSCP_IDX_IRQ_CLR, 8'h03);
        wr(`SSCP_IDX_DATA_LO, 8'hc3);
        setup_far(16'h005a, 5'd8);
        wr(`SSCP_IDX_CSR, 8'h01);
        pulses(5'd8);
        wait_idle();
        chk(rd[5], 1'b0);
        chk(rx_word[15:8], 8'hc3);
        rd_reg(`SSCP_IDX_DATA_LO);
        chk(rd, 8'h5a);
        pulses(5'd1);
        n = 0;
        do begin
            rd_reg(`SSCP_IDX_CSR);
            n++;
        end while (!rd[5] && n < 30);
        chk(rd[5], 1'b1);
        rd_reg(`SSCP_IDX_IRQ_STAT);
        chk(rd[1], 1'b1);
        wr(`SSCP_IDX_CSR, 8'h00);
        rd_reg(`SSCP_IDX_CSR);
        chk(rd[5], 1'b0);
        close_out();
    end
endmodule
